/* File: logic/i2c_ack_buffer_status_ctrl.sv */
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module i2c_ack_buffer_status_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  output logic             o_irq_req
);
  import i2c_ack_pkg::*;

  // ===========================================================
  // Pin synchronisers and edge detection
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_prev_q, sda_prev_q;
  logic       scl_s, sda_s;
  logic       scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (i_ce) begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  ctrl_t    ctrl_q;
  ext_cfg_t ext_q;

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = ctrl_q.ie & scl_s & ~scl_prev_q;
  assign scl_fall  = ctrl_q.ie & ~scl_s & scl_prev_q;
  assign start_det = ctrl_q.ie & scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = ctrl_q.ie & scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ===========================================================
  // Bus slave decode
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_CLR)
          || (a == ADDR_EXT) || (a == ADDR_DATA);
  endfunction : mapped

  logic       bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] wd;
  logic       wr_take, wr_en, rd_take;
  logic       wr_ctrl, wr_stat, wr_clr, wr_ext, wr_data_ev, rd_data_ev;
  logic       clr_pulse, soft_clr;

  assign wr_take    = i_ce & i_awvalid & i_wvalid & ~bvalid_q;
  assign rd_take    = i_ce & i_arvalid & ~rvalid_q;
  assign o_awready  = wr_take;
  assign o_wready   = wr_take;
  assign o_arready  = rd_take;
  assign wr_en      = wr_take & i_wstrb[0];
  assign wd         = i_wdata[7:0];
  assign wr_ctrl    = wr_en & (i_awaddr == ADDR_CTRL);
  assign wr_stat    = wr_en & (i_awaddr == ADDR_STAT);
  assign wr_clr     = wr_en & (i_awaddr == ADDR_CLR);
  assign wr_ext     = wr_en & (i_awaddr == ADDR_EXT);
  assign wr_data_ev = wr_en & (i_awaddr == ADDR_DATA) & ctrl_q.transmit_direction;
  // A read in transmit direction leaves the receive path alone
  assign rd_data_ev = rd_take & (i_araddr == ADDR_DATA) & ~ctrl_q.transmit_direction;
  // Only the two legal codes make a pulse
  assign clr_pulse  = wr_clr & ((wd[3:0] == CLR_CODE_A)
                             | (wd[3:0] == CLR_CODE_B));
  assign soft_clr   = clr_pulse | (wr_ctrl & ~wd[CTRL_IE]);

  // ===========================================================
  // Configuration registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= CTRL_RESET;
      ext_q  <= EXT_RESET;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_t'(wd[3:0]);
      end
      if (wr_ext) begin
        ext_q <= {wd[EXT_STOP_IRQ_MASK], wd[EXT_RX_HANDSHAKE_ENABLE], wd[EXT_ARB_LOST_IRQ_ENABLE]};
      end
    end
  end

  // ===========================================================
  // Frame position
  logic       busy_q;
  logic [3:0] cnt_q, idx;
  logic       frame_end, rx_done;

  assign idx       = (cnt_q == ACK_SLOT) ? 4'h0 : cnt_q;
  assign frame_end = busy_q & scl_rise & (idx == FRAME_BITS);
  assign rx_done   = frame_end & ~ctrl_q.transmit_direction;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else if (i_ce) begin
      if (soft_clr || start_det || stop_det) begin
        busy_q <= start_det & ~soft_clr;
        cnt_q  <= 4'h0;
      end else if (busy_q && scl_rise) begin
        cnt_q <= idx + 4'h1;
      end
    end
  end

  // ===========================================================
  // Shift register and buffers
  logic [7:0] sr_q, rx_buf_q, tx_buf_q;
  logic       rxf_q, rx_pend_q, rx_hold_q;
  logic       txe_q, tx_wait_q, waiting, nack_block;
  logic       tx_bit;

  assign tx_bit     = sr_q[3'(FRAME_BITS - 4'h1 - idx)];
  assign waiting    = tx_wait_q | (frame_end & ctrl_q.transmit_direction & txe_q);
  assign nack_block = ctrl_q.ack_check_enable & ctrl_q.fmt & sda_s;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sr_q <= 8'h00;
    end else if (i_ce) begin
      if (soft_clr) begin
        sr_q <= 8'h00;
      end else if (wr_data_ev && waiting) begin
        sr_q <= wd;
      end else if (frame_end && ctrl_q.transmit_direction && !txe_q && !nack_block) begin
        sr_q <= tx_buf_q;
      end else if (busy_q && scl_rise && !ctrl_q.transmit_direction
                   && idx < FRAME_BITS) begin
        sr_q <= {sr_q[6:0], sda_s};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_buf_q <= 8'h00;
    end else if (i_ce && wr_data_ev) begin
      tx_buf_q <= wd;
    end
  end

  // Transmit write request flag and wait state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      txe_q     <= 1'b0;
      tx_wait_q <= 1'b0;
    end else if (i_ce) begin
      if (soft_clr || stop_det) begin
        txe_q     <= 1'b0;
        tx_wait_q <= 1'b0;
      end else if (start_det) begin
        txe_q     <= 1'b1;
        tx_wait_q <= ctrl_q.transmit_direction;
      end else if (wr_data_ev) begin
        // Stays empty when waiting, the direct transfer takes the byte
        txe_q     <= waiting;
        tx_wait_q <= 1'b0;
      end else if (frame_end && ctrl_q.transmit_direction) begin
        if (txe_q) begin
          tx_wait_q <= 1'b1;
        end else if (!nack_block) begin
          txe_q <= 1'b1;
        end
      end
    end
  end

  // Receive read request flag; reader's pull has priority
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rxf_q     <= 1'b0;
      rx_pend_q <= 1'b0;
      rx_buf_q  <= 8'h00;
    end else if (i_ce) begin
      if (soft_clr) begin
        rxf_q     <= 1'b0;
        rx_pend_q <= 1'b0;
      end else if (rd_data_ev) begin
        rxf_q     <= rx_pend_q | rx_done;
        rx_pend_q <= 1'b0;
        if (rx_pend_q || rx_done) begin
          rx_buf_q <= sr_q;
        end
      end else if (rx_done) begin
        if (!rxf_q) begin
          rxf_q    <= 1'b1;
          rx_buf_q <= sr_q;
        end else begin
          rx_pend_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_hold_q <= 1'b0;
    end else if (i_ce) begin
      if (soft_clr) begin
        rx_hold_q <= 1'b0;
      end else if (rx_done) begin
        rx_hold_q <= 1'b1;
      end else if (rd_data_ev) begin
        rx_hold_q <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Clock stretching and SDA drive
  logic hold_cond, stretch_q, sda_drv_q;

  // Receiving without handshake, only an unread waiting frame stalls
  assign hold_cond = busy_q & (ctrl_q.transmit_direction ? tx_wait_q
                   : (ext_q.rx_handshake_enable ? rx_hold_q : rx_pend_q));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stretch_q <= 1'b0;
    end else if (i_ce) begin
      if (soft_clr || !hold_cond) begin
        stretch_q <= 1'b0;
      end else if (scl_fall && idx == 4'h0) begin
        stretch_q <= 1'b1;
      end
    end
  end

  logic al_q, ack_sw_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_drv_q <= 1'b0;
    end else if (i_ce) begin
      if (soft_clr || !busy_q || stop_det) begin
        sda_drv_q <= 1'b0;
      end else if (!scl_s) begin
        if (idx == FRAME_BITS) begin
          sda_drv_q <= ~ctrl_q.transmit_direction & ctrl_q.fmt & ~ack_sw_q;
        end else begin
          sda_drv_q <= ctrl_q.transmit_direction & ~al_q & ~tx_bit;
        end
      end
    end
  end

  assign o_scl    = 1'b0;
  assign o_scl_oe = stretch_q;
  assign o_sda    = 1'b0;
  assign o_sda_oe = sda_drv_q;

  // ===========================================================
  // Acknowledge bit
  logic ack_rx_q, ack_read, ack_ev;

  assign ack_ev = busy_q & scl_rise & ctrl_q.transmit_direction & ctrl_q.ack_check_enable
                & ctrl_q.fmt & (idx == FRAME_BITS);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_rx_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_ctrl && !wd[CTRL_ACK_CHECK_ENABLE]) begin
        ack_rx_q <= 1'b0;
      end else if (ack_ev) begin
        ack_rx_q <= sda_s;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_sw_q <= 1'b0;
    end else if (i_ce && wr_stat) begin
      ack_sw_q <= wd[STAT_ACK];
    end
  end

  assign ack_read = ctrl_q.transmit_direction ? ack_rx_q : ack_sw_q;

  // ===========================================================
  // Status flags and interrupt flag; a set beats a clear
  logic error_stop_flag_q, stop_q, irq_q, al_ev, stop_irq, al_irq;

  assign al_ev    = busy_q & scl_rise & ctrl_q.transmit_direction
                  & (idx < FRAME_BITS) & tx_bit & ~sda_s;
  assign stop_irq = stop_det & busy_q & ~ext_q.stop_irq_mask;
  assign al_irq   = al_ev & ext_q.arb_lost_irq_enable;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      error_stop_flag_q <= 1'b0;
      stop_q <= 1'b0;
      al_q   <= 1'b0;
      irq_q  <= 1'b0;
    end else if (i_ce) begin
      // Stop's own SCL rise already counts as bit one
      error_stop_flag_q <= (error_stop_flag_q & ~(wr_stat & ~wd[STAT_ERROR_STOP_FLAG]))
              | (stop_det & busy_q & (idx > 4'h1));
      stop_q <= (stop_q & ~(wr_stat & ~wd[STAT_STOP]))
              | (stop_det & busy_q & (idx <= 4'h1));
      al_q   <= (al_q & ~(wr_stat & ~wd[STAT_AL])) | al_ev;
      irq_q  <= (irq_q & ~(wr_stat & ~wd[STAT_IRQ]))
              | stop_irq | al_irq;
    end
  end

  assign o_irq_req = irq_q;

  // ===========================================================
  // Read data and responses
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (i_araddr)
      ADDR_CTRL: rd_byte = {4'h0, ctrl_q};
      ADDR_STAT: rd_byte = {error_stop_flag_q, stop_q, 2'h0, al_q, 1'b0,
                            irq_q, ack_read};
      ADDR_CLR:  rd_byte = CLR_READ;
      ADDR_EXT:  rd_byte = {ext_q.stop_irq_mask, ext_q.rx_handshake_enable, rxf_q, txe_q,
                            ext_q.arb_lost_irq_enable, 3'h0};
      ADDR_DATA: rd_byte = rx_buf_q;
      default:   rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OK;
    end else if (i_ce) begin
      if (wr_take) begin
        bvalid_q <= 1'b1;
        bresp_q  <= mapped(i_awaddr) ? RESP_OK : RESP_ERR;
      end else if (i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OK;
      rdata_q  <= 32'h0;
    end else if (i_ce) begin
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rresp_q  <= mapped(i_araddr) ? RESP_OK : RESP_ERR;
        rdata_q  <= {24'h0, rd_byte};
      end else if (i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp  = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp  = rresp_q;
  assign o_rdata  = rdata_q;

  // ===========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  ack_sample_a: assert property (i_ce && ack_ev && !wr_ctrl
    |=> ack_rx_q == $past(sda_s)) else $error("ack not stored");
  ack_clear_a: assert property (i_ce && wr_ctrl && !wd[CTRL_ACK_CHECK_ENABLE]
    |=> !ack_rx_q) else $error("ack not cleared");
  ack_drive_a: assert property (i_ce && busy_q && !scl_s
    && !ctrl_q.transmit_direction && ctrl_q.fmt && idx == FRAME_BITS && !soft_clr
    && !stop_det |=> sda_drv_q == !$past(ack_sw_q))
    else $error("ack drive wrong");
  ack_read_a: assert property (rd_take && i_araddr == ADDR_STAT
    |=> o_rdata[STAT_ACK] == $past(ack_read))
    else $error("ack read wrong");
  clr_pulse_a: assert property (i_ce && clr_pulse
    |=> !rxf_q && !txe_q && !busy_q) else $error("clear failed");
  clr_read_a: assert property (rd_take && i_araddr == ADDR_CLR
    |=> o_rdata == {24'h0, CLR_READ}) else $error("clear read");
  rx_move_a: assert property (i_ce && rx_done && !rxf_q && !soft_clr
    && !rd_data_ev |=> rxf_q && rx_buf_q == $past(sr_q))
    else $error("frame not moved");
  rx_refill_a: assert property (i_ce && rd_data_ev && rx_pend_q
    && !soft_clr |=> rxf_q && !rx_pend_q) else $error("no refill");
  no_stall_a: assert property (i_ce && busy_q && !ctrl_q.transmit_direction
    && !ext_q.rx_handshake_enable && !rx_pend_q |=> ##1 !stretch_q || !i_ce)
    else $error("stalled");
  tx_stop_a: assert property (i_ce && stop_det
    |=> !txe_q) else $error("write flag kept");
  tx_direct_a: assert property (i_ce && wr_data_ev && waiting
    && !soft_clr && !stop_det |=> txe_q && sr_q == $past(wd))
    else $error("no direct load");
  stop_irq_a: assert property (i_ce && stop_irq
    |=> irq_q) else $error("stop irq lost");

  rx_read_c: cover property (rx_done ##[1:400] rd_data_ev);
  tx_end_c:  cover property (frame_end && ctrl_q.transmit_direction);
  stop_c:    cover property (stop_det && busy_q);
  clr_c:     cover property (clr_pulse);
endmodule : i2c_ack_buffer_status_ctrl

/* File: logic/i2c_ack_pkg.sv */
package i2c_ack_pkg;
  // ===========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CLR  = 8'h08;
  localparam logic [7:0] ADDR_EXT  = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  // ===========================================================
  // Field positions
  localparam int CTRL_IE   = 0;
  localparam int CTRL_TRS  = 1;
  localparam int CTRL_ACK_CHECK_ENABLE = 2;
  localparam int CTRL_FMT  = 3;
  localparam int STAT_ERROR_STOP_FLAG = 7;
  localparam int STAT_STOP = 6;
  localparam int STAT_AL   = 3;
  localparam int STAT_IRQ  = 1;
  localparam int STAT_ACK  = 0;
  localparam int EXT_STOP_IRQ_MASK = 7;
  localparam int EXT_RX_HANDSHAKE_ENABLE   = 6;
  localparam int EXT_RXF    = 5;
  localparam int EXT_TXE    = 4;
  localparam int EXT_ARB_LOST_IRQ_ENABLE   = 3;
  // ===========================================================
  // Values
  localparam logic [3:0] CLR_CODE_A = 4'h5;
  localparam logic [3:0] CLR_CODE_B = 4'h7;
  localparam logic [7:0] CLR_READ   = 8'h0f;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT   = 4'h9;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  typedef struct packed {
    logic fmt;
    logic ack_check_enable;
    logic transmit_direction;
    logic ie;
  } ctrl_t;
  typedef struct packed {
    logic stop_irq_mask;
    logic rx_handshake_enable;
    logic arb_lost_irq_enable;
  } ext_cfg_t;
  localparam ctrl_t    CTRL_RESET = 4'h0;
  localparam ext_cfg_t EXT_RESET  = 3'h0;
endpackage : i2c_ack_pkg

/* File: sim/i2c_far_master.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-side bus master: open drain, SCL still between frames
module i2c_far_master (
  input  wire logic i_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  int half_cyc = 4;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  task automatic half();
    repeat (half_cyc) @(posedge i_clk);
  endtask : half
  // Device may stretch SCL, so wait for the wire, not the timer
  task automatic rise();
    o_scl_low <= 1'b0;
    do @(posedge i_clk); while (!i_scl);
    repeat (2 * half_cyc - 1) @(posedge i_clk);
  endtask : rise
  task automatic start();
    o_sda_low <= 1'b0;
    half();
    rise();
    o_sda_low <= 1'b1;
    half();
    o_scl_low <= 1'b1;
    half();
  endtask : start
  task automatic stop();
    o_sda_low <= 1'b1;
    half();
    rise();
    o_sda_low <= 1'b0;
    half();
  endtask : stop
  // Nine clocks MSB first; a 1 is sent by releasing SDA
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low <= !tx[i];
      half();
      rise();
      rx[i] = i_sda;
      o_scl_low <= 1'b1;
      half();
    end
  endtask : xfer
endmodule : i2c_far_master

/* File: sim/i2c_ack_buffer_status_ctrl_test.sv */
`timescale 1ns/1ps
module i2c_ack_buffer_status_ctrl_test;
  import i2c_ack_pkg::*;
  localparam int         LIMIT = 20000;
  localparam logic [7:0] RXF   = 8'(1 << EXT_RXF);
  localparam logic [7:0] TXF   = 8'(1 << EXT_TXE);
  localparam logic [7:0] HS    = 8'(1 << EXT_RX_HANDSHAKE_ENABLE);
  localparam logic [7:0] SM    = 8'(1 << EXT_STOP_IRQ_MASK);
  localparam logic [7:0] ALE   = 8'(1 << EXT_ARB_LOST_IRQ_ENABLE);
  localparam logic [7:0] C_RX  = 8'(1 << CTRL_IE | 1 << CTRL_FMT);
  localparam logic [7:0] C_TX  = C_RX | 8'(1 << CTRL_TRS);
  localparam logic [7:0] C_AK  = 8'(1 << CTRL_ACK_CHECK_ENABLE);
  logic        i_clk, i_arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, f;
  logic        scl_oe, sda_oe, scl_o, sda_o, m_scl_low, m_sda_low;
  logic        scl_w, sda_w;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, s;
  logic [8:0]  r;
  logic [3:0]  cl [6];
  int          err_count, n_checks, cyc;
  assign scl_w = !(m_scl_low | (scl_oe & !scl_o));
  assign sda_w = !(m_sda_low | (sda_oe & !sda_o));
  i2c_ack_buffer_status_ctrl uut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_scl(scl_w), .o_scl(scl_o),
    .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(sda_o),
    .o_sda_oe(sda_oe), .o_irq_req(irq));
  i2c_far_master far (.i_clk(i_clk), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      conclude();
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic chk(input string w, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    s = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask : rd
  // Upper bits must read zero, so they stay in the compare
  task automatic rc(input string w, input logic [7:0] a,
                    input logic [7:0] m, input logic [31:0] e);
    rd(a);
    chk(w, d & {24'hffffff, m}, e);
  endtask : rc
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // Tests
  initial begin
    {i_arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, err_count, n_checks, cyc} = '0;
    cl = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'hf};
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rc("ctrl reset", ADDR_CTRL, 8'hff, 0);
    rc("ext reset", ADDR_EXT, 8'hff, 0);
    rc("clear read", ADDR_CLR, 8'hff, 32'(CLR_READ));
    wr(ADDR_CLR, 8'h05);
    chk("write resp", 32'(s), 32'(RESP_OK));
    rc("clear kept", ADDR_CLR, 8'hff, 32'(CLR_READ));
    wr(ADDR_EXT, 8'hff);
    rc("ext access", ADDR_EXT, 8'hff, 32'(SM | HS | ALE));
    rd(8'h14);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", 32'(s), 32'(RESP_ERR));
    wr(8'h14, 8'h00);
    chk("unmapped wr", 32'(s), 32'(RESP_ERR));
    $display("registers done");
    wr(ADDR_EXT, HS);
    wr(ADDR_CTRL, C_RX);
    wr(ADDR_STAT, 8'h00);
    far.start();
    rc("tx flag start", ADDR_EXT, TXF, 32'(TXF));
    far.xfer({8'ha5, 1'b1}, r);
    chk("ack 0 driven", r[0], 0);
    chk("scl held", scl_oe, 1);
    rc("rx flag set", ADDR_EXT, RXF, 32'(RXF));
    rc("rx data", ADDR_DATA, 8'hff, 32'h0a5);
    rc("rx flag read", ADDR_EXT, RXF, 0);
    repeat (3) @(posedge i_clk);
    chk("scl freed", scl_oe, 0);
    wr(ADDR_STAT, 8'h01);
    rc("sw ack read", ADDR_STAT, 8'h01, 1);
    far.xfer({8'h3c, 1'b1}, r);
    chk("ack 1 driven", r[0], 1);
    rc("rx data 2", ADDR_DATA, 8'hff, 32'h03c);
    far.stop();
    rc("stop irq", ADDR_STAT, 8'h42, 32'h42);
    chk("irq out", irq, 1);
    rc("tx flag stop", ADDR_EXT, TXF, 0);
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_EXT, SM | HS);
    far.start();
    far.xfer({8'h5a, 1'b1}, r);
    rd(ADDR_DATA);
    far.stop();
    chk("stop masked", irq, 0);
    $display("receive done");
    wr(ADDR_EXT, SM);
    far.start();
    far.xfer({8'h11, 1'b1}, r);
    chk("no hold", scl_oe, 0);
    far.xfer({8'h22, 1'b1}, r);
    wr(ADDR_CTRL, C_TX);
    rd(ADDR_DATA);
    rc("tx mode read", ADDR_EXT, RXF, 32'(RXF));
    wr(ADDR_CTRL, C_RX);
    rc("first byte", ADDR_DATA, 8'hff, 32'h011);
    rc("refilled", ADDR_EXT, RXF, 32'(RXF));
    rc("waiting byte", ADDR_DATA, 8'hff, 32'h022);
    rc("rx empty", ADDR_EXT, RXF, 0);
    far.stop();
    $display("no handshake done");
    wr(ADDR_EXT, SM | HS);
    f = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (!f) begin
        far.start();
        far.xfer({8'h41, 1'b1}, r);
        f = 1'b1;
      end
      wr(ADDR_CLR, {4'h0, cl[i]});
      if (cl[i] == CLR_CODE_A || cl[i] == CLR_CODE_B) f = 1'b0;
      rc("clear code", ADDR_EXT, RXF, f ? 32'(RXF) : 0);
    end
    wr(ADDR_CTRL, 8'h00);
    rc("rx flag off", ADDR_EXT, RXF, 0);
    far.stop();
    $display("latch clear done");
    wr(ADDR_CTRL, C_TX | C_AK);
    wr(ADDR_STAT, 8'h00);
    far.start();
    wr(ADDR_DATA, 8'h96);
    rc("direct load", ADDR_EXT, TXF, 32'(TXF));
    far.xfer({8'hff, 1'b0}, r);
    chk("tx byte", r[8:1], 8'h96);
    rc("ack 0 seen", ADDR_STAT, 8'h01, 0);
    wr(ADDR_DATA, 8'h69);
    far.xfer({8'hff, 1'b1}, r);
    chk("tx byte 2", r[8:1], 8'h69);
    rc("ack 1 seen", ADDR_STAT, 8'h01, 1);
    wr(ADDR_CTRL, C_TX);
    rc("ack cleared", ADDR_STAT, 8'h01, 0);
    wr(ADDR_CTRL, 8'h00);
    rc("tx flag off", ADDR_EXT, TXF, 0);
    far.stop();
    $display("transmit done");
    for (int a = 0; a < 2; a++) begin
      wr(ADDR_EXT, SM | HS | (a[0] ? ALE : 8'h00));
      wr(ADDR_CTRL, C_TX);
      wr(ADDR_STAT, 8'h00);
      far.start();
      wr(ADDR_DATA, 8'hff);
      far.xfer({8'h00, 1'b0}, r);
      rc("arb lost", ADDR_STAT, 8'h08, 32'h08);
      chk("arb irq", irq, a[0]);
      wr(ADDR_CTRL, 8'h00);
      far.stop();
    end
    $display("arbitration done");
    conclude();
  end
endmodule : i2c_ack_buffer_status_ctrl_test
